// ===== design/urx_pkg.sv
// Package for the serial receive path: register map, fields, frame types
package urx_pkg;

  // Register byte offsets (word aligned)
  localparam logic [3:0] URX_OFF_DATA   = 4'h0;  // data_register
  localparam logic [3:0] URX_OFF_CSA    = 4'h4;  // ctrl_status_a
  localparam logic [3:0] URX_OFF_CSB    = 4'h8;  // ctrl_status_b
  localparam logic [3:0] URX_OFF_CSC    = 4'hc;  // ctrl_status_c

  // ctrl_status_a bit positions
  localparam int URX_A_RXC  = 7;
  localparam int URX_A_TXC  = 6;
  localparam int URX_A_DRE  = 5;
  localparam int URX_A_FE   = 4;
  localparam int URX_A_DOR  = 3;
  localparam int URX_A_UPE  = 2;

  // ctrl_status_b bit positions
  localparam int URX_B_RXCIE = 7;
  localparam int URX_B_RXEN  = 4;
  localparam int URX_B_TX_ENABLE  = 3;
  localparam int URX_B_SZ2   = 2;
  localparam int URX_B_RXB8  = 1;
  localparam int URX_B_TXB8  = 0;

  // ctrl_status_c bit positions
  localparam int URX_C_SYNC  = 6;
  localparam int URX_C_PEN   = 5;
  localparam int URX_C_PODD  = 4;
  localparam int URX_C_USBS  = 3;
  localparam int URX_C_SZ1   = 2;
  localparam int URX_C_SZ0   = 1;

  // Reset values
  localparam logic [7:0] URX_CSB_RST = 8'h00;
  localparam logic [7:0] URX_CSC_RST = 8'h06;  // Eight data bits

  // Character size code for nine bits
  localparam logic [2:0] URX_SZ_NINE = 3'h7;
  localparam logic [3:0] URX_SZ_BASE = 4'h5;
  localparam int         URX_FIFO_DEPTH = 2;

  // AXI responses
  localparam logic [1:0] URX_RESP_OKAY   = 2'h0;
  localparam logic [1:0] URX_RESP_SLVERR = 2'h2;

  // One stored frame with its status
  typedef struct packed {
    logic [8:0] data;
    logic       fe;
    logic       dor;
    logic       upe;
  } urx_entry_t;

  // Receive line state
  typedef enum logic [4:0] {
    URX_IDLE   = 5'b00001,
    URX_DATA   = 5'b00010,
    URX_PARITY = 5'b00100,
    URX_STOP   = 5'b01000,
    URX_HOLD   = 5'b10000
  } urx_state_t;

endpackage

// ===== design/urx_fifo.sv
// Two-entry receive FIFO holding frames with their error status
`timescale 1ns/1ns
module urx_fifo #(
  parameter int DEPTH = 2
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              flush,
  input  wire logic              push,
  input  wire urx_pkg::urx_entry_t din,
  input  wire logic              pop,
  output urx_pkg::urx_entry_t    head,
  output logic                   full,
  output logic                   empty
);
  import urx_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  urx_entry_t          mem_q [DEPTH];
  logic [AW-1:0]       wr_q;
  logic [AW-1:0]       rd_q;
  logic [AW:0]         cnt_q;

  assign head  = mem_q[rd_q];
  assign full  = (cnt_q == (AW+1)'(DEPTH));
  assign empty = (cnt_q == '0);

  // Storage; a push while full is ignored here
  always_ff @(posedge aclk)
  begin
    if (push && !full)
      mem_q[wr_q] <= din;
  end

  // Pointers and fill count; flush wins over everything
  always_ff @(posedge aclk)
  begin
    if (!aresetn || flush)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push && !full)
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      if (pop && !empty)
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push && !full) - (AW+1)'(pop && !empty);
    end
  end
endmodule

// ===== design/urx_top.sv
// Serial receive path with parity, transmitter disable and AXI4-Lite registers
//
// Summary of operation
// - Parity bit goes between data and stop
// - Transmitter disable waits for empty shift/buffer
// - rx_enable gives receiver the rx_pin
// - Synchronous mode samples on sync_clock_pin rising edges
// - Start bit begins frame; second stop ignored
// - First stop bit moves frame into FIFO
// - Unused upper data bits read zero
// - Ninth bit and flags stored per entry
// - rx_complete_flag set while FIFO not empty
// - rx_enable clear discards, flushes, releases pin
// - Interrupt level while flag and enable set
// - Error flags ignore writes, raise no interrupt
// - Frame error reflects first stop bit
// - Overrun when full, waiting, new start
// - Overrun clears on successful FIFO transfer
// - Parity error zero when checking disabled
// - Receiver checks parity with chosen sense
// - Parity error per head frame until read
`timescale 1ns/1ns
module urx_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial side
  input  wire logic        baud_tick,
  input  wire logic        rx_pin,
  input  wire logic        sync_clock_pin,
  input  wire logic        tx_busy,
  output logic             tx_parity_bit,
  output logic             tx_enable_eff,
  output logic             rx_pin_owned,
  output logic             rx_complete_irq
);
  import urx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]   csb_q;
  logic [7:0]   csc_q;
  logic         txc_q;
  logic         tx_pend_q;  // Transmit buffer holding data for the shifter
  logic [7:0]   tx_data_q;
  logic         tx_b8_q;
  logic [3:0]   waddr_q;    // Address of the write being completed
  logic         wr_fire;    // Write address and data both held
  logic [7:0]   wb;         // Low byte of the held write data

  logic         rx_en;
  logic         par_en;
  logic         par_odd;
  logic [2:0]   sz;
  logic [3:0]   nbits;

  assign rx_en   = csb_q[URX_B_RXEN];
  assign par_en  = csc_q[URX_C_PEN];
  assign par_odd = csc_q[URX_C_PODD];
  assign sz      = {csb_q[URX_B_SZ2], csc_q[URX_C_SZ1], csc_q[URX_C_SZ0]};
  assign nbits   = (sz == URX_SZ_NINE) ? 4'h9 : (URX_SZ_BASE + {1'b0, sz});

  ////////////////////////////////////////////////////////////////////////////
  // Sampling strobe: baud tick or rising edge of the transfer clock
  logic         sclk_q;
  logic         sample;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sclk_q <= 1'b0;
    else
      sclk_q <= sync_clock_pin;
  end
  assign sample = csc_q[URX_C_SYNC] ? (sync_clock_pin && !sclk_q) : baud_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Receive deframer
  urx_state_t   st_q;
  logic [8:0]   sh_q;
  logic [3:0]   bit_q;
  logic         par_acc_q;  // Running XOR of data bits
  logic         perr_q;
  urx_entry_t   hold_q;     // Completed frame waiting for FIFO room
  logic         dor_q;      // Overrun pending for next stored frame
  logic         fifo_full;
  logic         fifo_empty;
  logic         push;
  logic         pop;
  urx_entry_t   head;
  urx_entry_t   frame;
  urx_entry_t   fifo_din;   // Held frame with its overrun mark
  logic         start_seen;

  assign start_seen = sample && !rx_pin;
  // frame error from first stop bit
  assign frame = '{data: sh_q, fe: !rx_pin, dor: 1'b0, upe: par_en && perr_q};
  assign push  = (st_q == URX_HOLD) && !fifo_full;
  // Overrun pending joins the held frame as it enters the FIFO
  assign fifo_din = '{data: hold_q.data, fe: hold_q.fe, dor: dor_q, upe: hold_q.upe};

  // start, data, optional parity, one stop
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_en)
    begin
      st_q      <= URX_IDLE;
      sh_q      <= '0;
      bit_q     <= '0;
      par_acc_q <= 1'b0;
      perr_q    <= 1'b0;
      hold_q    <= '0;
    end
    else
    begin
      case (st_q)
        URX_IDLE:
          if (start_seen)
          begin
            st_q      <= URX_DATA;
            sh_q      <= '0;
            bit_q     <= '0;
            par_acc_q <= 1'b0;
          end
        URX_DATA:
          if (sample)
          begin
            // LSB first, upper bits stay zero
            sh_q[bit_q] <= rx_pin;
            par_acc_q   <= par_acc_q ^ rx_pin;
            bit_q       <= bit_q + 4'h1;
            if (bit_q == nbits - 4'h1)
              st_q <= par_en ? URX_PARITY : URX_STOP;
          end
        URX_PARITY:
          if (sample)
          begin
            perr_q <= (par_acc_q ^ par_odd) != rx_pin;
            st_q   <= URX_STOP;
          end
        URX_STOP:
          if (sample)
          begin
            hold_q <= frame;
            perr_q <= 1'b0;
            st_q   <= URX_HOLD;
          end
        URX_HOLD:
          // Frame waits here while the FIFO is full
          if (!fifo_full)
            st_q <= URX_IDLE;
        default:
          st_q <= URX_IDLE;
      endcase
    end
  end

  // full FIFO, waiting frame and new start
  // cleared once a frame is stored
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_en)
      dor_q <= 1'b0;
    else if (st_q == URX_HOLD && fifo_full && start_seen)
      dor_q <= 1'b1;
    else if (push)
      dor_q <= 1'b0;
  end

  urx_fifo #(
    .DEPTH (URX_FIFO_DEPTH)
  ) u_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .flush   (!rx_en),
    .push    (push),
    .din     (fifo_din),
    .pop     (pop),
    .head    (head),
    .full    (fifo_full),
    .empty   (fifo_empty)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side: parity bit and deferred disable
  logic [8:0]   tx_word;
  logic [8:0]   tx_mask;
  assign tx_mask = 9'h1ff >> (4'h9 - nbits);
  assign tx_word = {tx_b8_q, tx_data_q} & tx_mask;

  // parity bit presented for insertion after data
  // even when zero, odd when one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_parity_bit <= 1'b0;
    else
      tx_parity_bit <= par_en & ((^tx_word) ^ par_odd);
  end

  // disable waits for shifter and buffer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_enable_eff <= 1'b0;
    else if (csb_q[URX_B_TX_ENABLE])
      tx_enable_eff <= 1'b1;
    else if (!tx_busy && !tx_pend_q)
      tx_enable_eff <= 1'b0;
  end

  // Transmit complete and buffer state from the shifter handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_pend_q <= 1'b0;
      txc_q     <= 1'b0;
    end
    else
    begin
      if (wr_fire && waddr_q == URX_OFF_DATA)
        tx_pend_q <= 1'b1;
      else if (!tx_busy)
        tx_pend_q <= 1'b0;
      if (!tx_busy && !tx_pend_q && tx_enable_eff)
        txc_q <= 1'b1;
      else if (wr_fire && waddr_q == URX_OFF_CSA && wb[URX_A_TXC])
        txc_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_pin_owned    <= 1'b0;
      rx_complete_irq <= 1'b0;
    end
    else
    begin
      rx_pin_owned    <= rx_en;
      rx_complete_irq <= csb_q[URX_B_RXCIE] && rx_en && !fifo_empty;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data in either order
  logic         aw_have_q;
  logic         w_have_q;
  logic [31:0]  wdata_q;

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wb      = wdata_q[7:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      waddr_q       <= '0;
      wdata_q       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= URX_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !s_axi_awready;
      s_axi_wready  <= !w_have_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        waddr_q   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
      end
      if (wr_fire)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (waddr_q[1:0] == 2'h0) ? URX_RESP_OKAY : URX_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; ctrl_status_a error bits are read only
  // writes cannot reach error flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      csb_q     <= URX_CSB_RST;
      csc_q     <= URX_CSC_RST;
      tx_data_q <= '0;
      tx_b8_q   <= 1'b0;
    end
    else if (wr_fire)
    begin
      if (waddr_q == URX_OFF_DATA)
        tx_data_q <= wb;
      else if (waddr_q == URX_OFF_CSB)
      begin
        csb_q   <= wb & 8'hfd;     // Ninth received bit is read only
        tx_b8_q <= wb[URX_B_TXB8];
      end
      else if (waddr_q == URX_OFF_CSC)
        csc_q <= wb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel; a data read pops the FIFO head
  logic [7:0]   rd_byte;

  assign pop = s_axi_arvalid && s_axi_arready && (s_axi_araddr == URX_OFF_DATA);

  // Read mux from current head and register state
  always_comb
  begin
    rd_byte = 8'h00;
    if (s_axi_araddr == URX_OFF_DATA)
      rd_byte = fifo_empty ? 8'h00 : head.data[7:0];
    else if (s_axi_araddr == URX_OFF_CSA)
    begin
      rd_byte[URX_A_RXC] = !fifo_empty;
      rd_byte[URX_A_TXC] = txc_q;
      rd_byte[URX_A_DRE] = !tx_pend_q;
      // head frame status until data read
      rd_byte[URX_A_FE]  = !fifo_empty && head.fe;
      rd_byte[URX_A_DOR] = !fifo_empty && head.dor;
      rd_byte[URX_A_UPE] = !fifo_empty && head.upe;
    end
    else if (s_axi_araddr == URX_OFF_CSB)
    begin
      rd_byte = csb_q;
      rd_byte[URX_B_RXB8] = !fifo_empty && head.data[8];
    end
    else if (s_axi_araddr == URX_OFF_CSC)
      rd_byte = csc_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= URX_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= (s_axi_araddr[1:0] == 2'h0) ? URX_RESP_OKAY : URX_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ===== sim/urx_top_asserts.sv
// Port-level assertions for the serial receive path
`timescale 1ns/1ns
module urx_top_asserts
  import urx_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        tx_busy,
  input wire logic        tx_enable_eff,
  input wire logic        rx_pin_owned,
  input wire logic        rx_complete_irq
);
  logic [3:0] since_w_q;

  // Cycles since the last write data handshake; saturates so it never wraps
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      since_w_q <= 4'hf;
    else if (s_axi_wvalid && s_axi_wready)
      since_w_q <= 4'h0;
    else if (since_w_q != 4'hf)
      since_w_q <= since_w_q + 4'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////////
  irq_needs_own_a: assert property (rx_complete_irq |-> rx_pin_owned)
    else $error("receive interrupt while receiver disabled");
  tx_busy_hold_a: assert property (tx_enable_eff && tx_busy |=> tx_enable_eff)
    else $error("transmitter released while busy");
  rx_own_wr_a: assert property ($rose(rx_pin_owned) |-> since_w_q <= 4)
    else $error("receive pin taken without a register write");
  tx_own_wr_a: assert property ($rose(tx_enable_eff) |-> since_w_q <= 4)
    else $error("transmit pin taken without a register write");
  b_after_w_a: assert property ($rose(s_axi_bvalid) |-> since_w_q <= 2)
    else $error("write response without write data");
  r_after_ar_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read data without read address");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after handshake");
  bad_addr_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
    |=> s_axi_rvalid && s_axi_rresp == URX_RESP_SLVERR)
    else $error("unaligned read not refused");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");

  // Main scenarios reached
  cover property ($rose(rx_complete_irq));
  cover property ($fell(tx_enable_eff));
  cover property ($fell(rx_pin_owned));
endmodule

bind urx_top urx_top_asserts i_urx_top_asserts (.aclk, .aresetn, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .tx_busy, .tx_enable_eff, .rx_pin_owned, .rx_complete_irq);

// ===== sim/urx_line_model.sv
// Remote serial transmitter driving the receive line and its strobes
`timescale 1ns/1ns
module urx_line_model (
  input  wire logic aclk,
  output logic      baud_tick,
  output logic      rx_pin,
  output logic      sync_clock_pin
);
  // Line idles at mark; transfer clock stands still between frames
  initial
  begin
    baud_tick = 1'b0;
    rx_pin = 1'b1;
    sync_clock_pin = 1'b0;
  end

  // One bit: level settles first, then a single strobe on tick or transfer clock
  task bit_out(input logic b, input logic sm);
    rx_pin <= b;
    repeat (2) @(posedge aclk);
    if (sm)
      sync_clock_pin <= 1'b1;
    else
      baud_tick <= 1'b1;
    @(posedge aclk);
    baud_tick <= 1'b0;
    repeat (2) @(posedge aclk);
    sync_clock_pin <= 1'b0;
    @(posedge aclk);
  endtask

  // idle strobe, start, data first bit lowest, parity, stop
  task send(input logic [8:0] d, input int n, input logic pen, input logic podd, input logic perr,
            input logic stop, input logic sm);
    int   k;
    logic p;
    p = podd ^ perr;
    bit_out(1'b1, sm);
    bit_out(1'b0, sm);
    for (k = 0; k < n; k++)
    begin
      bit_out(d[k], sm);
      p = p ^ d[k];
    end
    if (pen)
      bit_out(p, sm);
    bit_out(stop, sm);
  endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the serial receive path
`timescale 1ns/1ns
module testbench;
  import urx_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, tx_busy = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        baud_tick, rx_pin, sync_clock_pin, tx_parity_bit, tx_enable_eff, rx_pin_owned, rx_complete_irq;
  logic [31:0] s_axi_rdata, rd_val;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp_q;
  int          miscompares = 0, cmp_count = 0;

  urx_top i_urx_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .baud_tick,
    .rx_pin, .sync_clock_pin, .tx_busy, .tx_parity_bit, .tx_enable_eff, .rx_pin_owned, .rx_complete_irq);
  urx_line_model i_urx_line_model (.aclk, .baud_tick, .rx_pin, .sync_clock_pin);

  // 100 MHz clock
  always #5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task end_sim;
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A wait that ran out counts as a mismatch
  task hang;
    miscompares++;
    end_sim;
  endtask

  // Write: first edge keeps handshake signals from being driven twice in one step
  task axi_wr(input logic [3:0] a, input logic [7:0] d);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        resp_q = s_axi_bresp;
        return;
      end
    end
    hang;
  endtask

  // Read into rd_val and resp_q
  task axi_rd(input logic [3:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        rd_val = s_axi_rdata;
        resp_q = s_axi_rresp;
        return;
      end
    end
    hang;
  endtask

  // Poll until a frame is present
  task wait_rxc;
    int i;
    for (i = 0; i < 40; i++)
    begin
      axi_rd(URX_OFF_CSA);
      if (rd_val[URX_A_RXC] === 1'b1)
        return;
    end
    hang;
  endtask

  // Status first, then ninth bit, then data, since the data read pops the entry
  task rd_frame(input logic [8:0] d, input logic [2:0] err, input logic nine);
    wait_rxc;
    axi_rd(URX_OFF_CSA);
    chk("status", {29'h0, rd_val[URX_A_FE], rd_val[URX_A_DOR], rd_val[URX_A_UPE]}, {29'h0, err});
    axi_rd(URX_OFF_CSB);
    if (nine)
      chk("ninth", {31'h0, rd_val[URX_B_RXB8]}, {31'h0, d[8]});
    axi_rd(URX_OFF_DATA);
    chk("data", rd_val, {24'h0, d[7:0]});
  endtask

  // Settling time for registered outputs after a register write
  task settle;
    repeat (3) @(posedge aclk);
  endtask

  // Reset values and refused addresses
  task t_regs;
    axi_rd(URX_OFF_CSC);
    chk("csc_rst", rd_val, {24'h0, URX_CSC_RST});
    axi_rd(URX_OFF_CSB);
    chk("csb_rst", rd_val, {24'h0, URX_CSB_RST});
    axi_rd(4'h2);
    chk("rresp", {30'h0, resp_q}, {30'h0, URX_RESP_SLVERR});
    axi_wr(4'h6, 8'hff);
    chk("bresp", {30'h0, resp_q}, {30'h0, URX_RESP_SLVERR});
  endtask

  // Five-bit frame, parity off: upper bits and parity flag read zero
  task t_five;
    axi_wr(URX_OFF_CSC, 8'h00);
    axi_wr(URX_OFF_CSB, 8'h10);
    settle;
    chk("own", {31'h0, rx_pin_owned}, 32'h1);
    i_urx_line_model.send(9'h1f5, 5, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    rd_frame(9'h015, 3'h0, 1'b0);
    axi_rd(URX_OFF_CSA);
    chk("rxc", {31'h0, rd_val[URX_A_RXC]}, 32'h0);
  endtask

  // Nine bits with parity of both senses, errors, overrun and interrupt
  task t_nine;
    int k;
    axi_wr(URX_OFF_CSB, 8'h94);
    for (k = 0; k < 2; k++)
    begin
      axi_wr(URX_OFF_CSC, k ? 8'h36 : 8'h26);
      i_urx_line_model.send(9'h1a5, 9, 1'b1, k[0], 1'b0, 1'b1, 1'b0);
      chk("irq", {31'h0, rx_complete_irq}, 32'h1);
      i_urx_line_model.send(9'h05a, 9, 1'b1, k[0], 1'b1, 1'b0, 1'b0);
      i_urx_line_model.send(9'h133, 9, 1'b1, k[0], 1'b0, 1'b1, 1'b0);
      i_urx_line_model.bit_out(1'b0, 1'b0);
      i_urx_line_model.bit_out(1'b1, 1'b0);
      rd_frame(9'h1a5, 3'h0, 1'b1);
      axi_wr(URX_OFF_CSA, 8'h00);
      rd_frame(9'h05a, 3'h5, 1'b1);
      rd_frame(9'h133, 3'h2, 1'b1);
      axi_rd(URX_OFF_CSA);
      chk("rxc", {31'h0, rd_val[URX_A_RXC]}, 32'h0);
    end
    chk("irq", {31'h0, rx_complete_irq}, 32'h0);
  endtask

  // Receiver disable mid-frame with a frame stored: flush, abort, release
  task t_off;
    i_urx_line_model.send(9'h0c3, 9, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    i_urx_line_model.bit_out(1'b0, 1'b0);
    i_urx_line_model.bit_out(1'b1, 1'b0);
    axi_wr(URX_OFF_CSB, 8'h84);
    axi_rd(URX_OFF_CSA);
    chk("flush", {31'h0, rd_val[URX_A_RXC]}, 32'h0);
    chk("own_off", {31'h0, rx_pin_owned}, 32'h0);
    chk("irq_off", {31'h0, rx_complete_irq}, 32'h0);
    axi_wr(URX_OFF_CSB, 8'h94);
    i_urx_line_model.send(9'h13c, 9, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    rd_frame(9'h13c, 3'h0, 1'b1);
  endtask

  // Synchronous mode with two stop bits selected: only the first stop decides the frame error
  task t_sync;
    axi_wr(URX_OFF_CSB, 8'h10);
    axi_wr(URX_OFF_CSC, 8'h4e);
    i_urx_line_model.send(9'h0a6, 8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    rd_frame(9'h0a6, 3'h4, 1'b0);
  endtask

  // Transmit parity of both senses, disable held off while busy
  task t_tx;
    tx_busy <= 1'b1;
    axi_wr(URX_OFF_CSB, 8'h08);
    axi_wr(URX_OFF_CSC, 8'h26);
    axi_wr(URX_OFF_DATA, 8'h07);
    settle;
    chk("par_even", {31'h0, tx_parity_bit}, 32'h1);
    axi_wr(URX_OFF_CSC, 8'h36);
    settle;
    chk("par_odd", {31'h0, tx_parity_bit}, 32'h0);
    axi_wr(URX_OFF_CSB, 8'h00);
    settle;
    chk("tx_hold", {31'h0, tx_enable_eff}, 32'h1);
    tx_busy <= 1'b0;
    settle;
    chk("tx_off", {31'h0, tx_enable_eff}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_five;
    t_nine;
    t_off;
    t_sync;
    t_tx;
    end_sim;
  end
endmodule
